// *** core/ctxm_code_mem.sv ***
// mailbox code store with registered read port
`timescale 1ns/1ps
`default_nettype none
`include "ctxm_map.svh"
module ctxm_code_mem (
	// clock and reset
	input  wire logic                       clk,
	input  wire logic                       resetn,
	// write port
	input  wire logic                       wr_en,
	input  wire logic [`CTXM_MB_IDX_W-1:0]  wr_idx,
	input  wire logic [`CTXM_CODE_W-1:0]    wr_code,
	// read port
	input  wire logic [`CTXM_MB_IDX_W-1:0]  rd_idx,
	output logic      [`CTXM_CODE_W-1:0]    rd_code
);
	logic [`CTXM_CODE_W-1:0] mem_r [`CTXM_NUM_MB];
	logic [`CTXM_CODE_W-1:0] rd_r;
	// storage; all mailboxes start inactive
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < `CTXM_NUM_MB; i++) mem_r[i] <= `CTXM_CODE_INACT0;
			rd_r <= `CTXM_CODE_INACT0;
		end else begin
			if (wr_en) mem_r[wr_idx] <= wr_code;
			rd_r <= mem_r[rd_idx];
		end
	end
	assign rd_code = rd_r;
endmodule : ctxm_code_mem
`default_nettype wire

// *** core/ctxm_flag_bank.sv ***
// per-buffer completion flags with mask gating
`timescale 1ns/1ps
`default_nettype none
`include "ctxm_map.svh"
module ctxm_flag_bank (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	// set and clear vectors, interrupt mask
	input  wire logic [`CTXM_NUM_MB-1:0] set_vec,
	input  wire logic [`CTXM_NUM_MB-1:0] clr_vec,
	input  wire logic [`CTXM_NUM_MB-1:0] mask,
	// state
	output logic      [`CTXM_NUM_MB-1:0] flags,
	output logic                         irq_any
);
	logic [`CTXM_NUM_MB-1:0] flag_r, flag_nxt;
	// set beats clear in the same cycle so no event is lost
	always_comb begin
		flag_nxt = (flag_r & ~clr_vec) | set_vec;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) flag_r <= '0;
		else         flag_r <= flag_nxt;
	end
	assign flags   = flag_r;
	assign irq_any = |(flag_r & mask);
endmodule : ctxm_flag_bank
`default_nettype wire

// *** core/ctxm_map.svh ***
// constants for the transmit mailbox control block
`ifndef CTXM_MAP_SVH
`define CTXM_MAP_SVH
`define CTXM_NUM_MB       16
`define CTXM_MB_IDX_W     4
`define CTXM_CODE_W       4
`define CTXM_CODE_INACT0  4'h0
`define CTXM_CODE_INACT   4'h8
`define CTXM_CODE_ABORT   4'h9
`define CTXM_CODE_TX      4'hC
`define CTXM_CODE_ABORTED 4'h9
`define CTXM_CODE_SENT    4'h8
`define CTXM_RESCAN_CYC   1
`endif

// *** core/ctxm_pkg.sv ***
// types for the transmit mailbox control block
package ctxm_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_SEND} ctxm_state_type;
endpackage : ctxm_pkg

// *** core/ctxm_tx_mailbox_ctrl.sv ***
// transmit mailbox control: codes, abort handshake, flags and arbitration rescan
//
// Notes on behaviour
// - writing code zero deactivates a mailbox so it can be reconfigured
// - code twelve arms a mailbox for transmit in the next arbitration
// - abort code on an active mailbox requests abort of its pending frame
// - after an abort request the mailbox completion flag is set
// - a completion flag raises the interrupt only when its mask bit is set
// - after the flag, the readable code shows aborted or transmitted, unless a host write dropped its waiting sent code
// - with abort_enable low, inactive code deactivates silently; frame may still go
// - a transmit code written just before the scan is still caught and rescheduled
// - the old loss needed one armed mailbox and an idle bus afterwards
// - a control status write after intermission triggers a rescan
// - a frame start after intermission also triggers a fresh arbitration
`timescale 1ns/1ps
`default_nettype none
`include "ctxm_map.svh"
module ctxm_tx_mailbox_ctrl
	import ctxm_pkg::*;
(
	// clock and reset
	input  wire logic                        clk,
	input  wire logic                        resetn,
	// host code write
	input  wire logic                        cs_wr,
	input  wire logic [`CTXM_MB_IDX_W-1:0]   cs_idx,
	input  wire logic [`CTXM_CODE_W-1:0]     cs_code,
	// host flag clear and configuration
	input  wire logic [`CTXM_NUM_MB-1:0]     flag_clr,
	input  wire logic [`CTXM_NUM_MB-1:0]     buffer_int_mask,
	input  wire logic                        abort_enable,
	// code readback
	input  wire logic [`CTXM_MB_IDX_W-1:0]   rd_idx,
	output logic      [`CTXM_CODE_W-1:0]     rd_code,
	// bus engine side
	input  wire logic                        intermission_end,
	input  wire logic                        rx_frame_start,
	input  wire logic                        tx_done,
	input  wire logic                        tx_busy,
	output logic                             tx_req,
	output logic      [`CTXM_MB_IDX_W-1:0]   tx_idx,
	// status
	output logic      [`CTXM_NUM_MB-1:0]     buffer_done_flag,
	output logic                             irq,
	output logic                             rescan_pending
);
	ctxm_state_type state_r, state_nxt;
	logic [`CTXM_MB_IDX_W-1:0] scan_r, scan_nxt;
	logic [`CTXM_MB_IDX_W-1:0] sel_r, sel_nxt;
	logic                      found_r, found_nxt;
	logic [`CTXM_NUM_MB-1:0]   armed_r, armed_nxt;
	logic [`CTXM_NUM_MB-1:0]   abt_r, abt_nxt;
	logic                      pend_r, pend_nxt;
	logic                      tx_req_r, tx_req_nxt;
	logic [`CTXM_MB_IDX_W-1:0] tx_idx_r, tx_idx_nxt;
	logic                      irq_r;
	logic [`CTXM_NUM_MB-1:0]   set_vec, flags;
	logic                      irq_any;
	logic                      mem_wr;
	logic [`CTXM_MB_IDX_W-1:0] mem_idx;
	logic [`CTXM_CODE_W-1:0]   mem_code;
	logic                      last_scan;
	// sent-code write-back held while the host owns the memory write port
	logic                      done_live;
	logic                      hw_wr;
	logic [`CTXM_MB_IDX_W-1:0] hw_idx;
	logic                      wb_pend_r, wb_pend_nxt;
	logic [`CTXM_MB_IDX_W-1:0] wb_idx_r, wb_idx_nxt;

	// one-hot of a mailbox index
	function automatic logic [`CTXM_NUM_MB-1:0] onehot(input logic [`CTXM_MB_IDX_W-1:0] i);
		onehot = '0;
		onehot[i] = 1'b1;
	endfunction : onehot

	////////////////////////////////////////////////////////////////////////////
	// storage instances
	ctxm_code_mem u_mem (
		.clk     (clk),
		.resetn  (resetn),
		.wr_en   (mem_wr),
		.wr_idx  (mem_idx),
		.wr_code (mem_code),
		.rd_idx  (rd_idx),
		.rd_code (rd_code)
	);
	ctxm_flag_bank u_flags (
		.clk     (clk),
		.resetn  (resetn),
		.set_vec (set_vec),
		.clr_vec (flag_clr),
		.mask    (buffer_int_mask),
		.flags   (flags),
		.irq_any (irq_any)
	);

	////////////////////////////////////////////////////////////////////////////
	// code writes from host, and hardware code updates on completion
	// a completion only counts while the mailbox is still armed: inactivated ones stay silent
	assign done_live = tx_done && armed_r[tx_idx_r];
	always_comb begin
		armed_nxt   = armed_r;
		abt_nxt     = abt_r;
		set_vec     = '0;
		// sent-code write: a fresh completion first, else one left waiting from a busy port
		hw_wr       = done_live || wb_pend_r;
		hw_idx      = done_live ? tx_idx_r : wb_idx_r;
		wb_pend_nxt = done_live && wb_pend_r; // two at once: the older one keeps waiting
		wb_idx_nxt  = wb_idx_r;
		mem_wr      = hw_wr;
		mem_idx     = hw_idx;
		mem_code    = `CTXM_CODE_SENT;
		// frame finished: mailbox released, flag set unless it was inactivated on the wire
		if (tx_done) begin
			armed_nxt[tx_idx_r] = 1'b0;
			abt_nxt[tx_idx_r]   = 1'b0;
			if (done_live) set_vec = onehot(tx_idx_r);
		end
		if (cs_wr) begin
			// the host owns the single write port; a clashing sent-code write to another mailbox waits for a cycle with no host write.
			// limitation: a host write on top of two pending sent-codes drops the older one
			if (hw_wr && hw_idx != cs_idx) begin
				wb_pend_nxt = 1'b1;
				wb_idx_nxt  = hw_idx;
			end
			mem_wr   = 1'b1;
			mem_idx  = cs_idx;
			mem_code = cs_code;
			case (cs_code)
				`CTXM_CODE_TX: begin
					armed_nxt[cs_idx] = 1'b1;
					abt_nxt[cs_idx]   = 1'b0;
				end
				`CTXM_CODE_ABORT: begin
					if (abort_enable && armed_r[cs_idx]) begin
						// busy on the wire: abort lands after the frame ends
						if (tx_busy && tx_idx_r == cs_idx) begin
							abt_nxt[cs_idx] = 1'b1;
							mem_code = `CTXM_CODE_TX;
						end else begin
							armed_nxt[cs_idx] = 1'b0;
							set_vec[cs_idx]   = 1'b1;
							mem_code = `CTXM_CODE_ABORTED;
						end
					end
				end
				`CTXM_CODE_INACT: begin
					// silent: an in-flight frame may still go out
					armed_nxt[cs_idx] = 1'b0;
					abt_nxt[cs_idx]   = 1'b0;
				end
				`CTXM_CODE_INACT0: begin
					armed_nxt[cs_idx] = 1'b0;
					abt_nxt[cs_idx]   = 1'b0;
				end
				default: begin
					armed_nxt[cs_idx] = 1'b0;
					abt_nxt[cs_idx]   = 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// arbitration scan: walks all mailboxes, lowest armed index wins
	assign last_scan = (scan_r == `CTXM_MB_IDX_W'(`CTXM_NUM_MB - 1));
	always_comb begin
		state_nxt  = state_r;
		scan_nxt   = scan_r;
		sel_nxt    = sel_r;
		found_nxt  = found_r;
		tx_req_nxt = 1'b0;
		tx_idx_nxt = tx_idx_r;
		pend_nxt   = pend_r;
		// any code write during the scan or at a frame boundary is remembered
		if (cs_wr) pend_nxt = 1'b1;
		if (intermission_end || rx_frame_start) pend_nxt = 1'b1;
		case (state_r)
			ST_IDLE: begin
				if (pend_r && !tx_busy) begin
					state_nxt = ST_SCAN;
					scan_nxt  = '0;
					found_nxt = 1'b0;
					pend_nxt  = cs_wr; // a write now still counts for a rescan
				end
			end
			ST_SCAN: begin
				if (armed_nxt[scan_r] && !found_r) begin
					found_nxt = 1'b1;
					sel_nxt   = scan_r;
				end
				if (last_scan) begin
					state_nxt = ST_IDLE;
					if (found_nxt) begin
						// drop the winner if it was disarmed this very cycle
						if (armed_nxt[found_r ? sel_r : scan_r]) begin
							tx_req_nxt = 1'b1;
							tx_idx_nxt = found_r ? sel_r : scan_r;
							state_nxt  = ST_SEND;
						end else begin
							pend_nxt = 1'b1;
						end
					end
				end else begin
					scan_nxt = scan_r + `CTXM_MB_IDX_W'(1);
				end
			end
			ST_SEND: begin
				if (tx_done) state_nxt = ST_IDLE;
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r  <= ST_IDLE;
			scan_r   <= '0;
			sel_r    <= '0;
			found_r  <= 1'b0;
			armed_r  <= '0;
			abt_r    <= '0;
			pend_r   <= 1'b0;
			tx_req_r <= 1'b0;
			tx_idx_r <= '0;
			irq_r    <= 1'b0;
			wb_pend_r <= 1'b0;
			wb_idx_r  <= '0;
		end else begin
			state_r  <= state_nxt;
			scan_r   <= scan_nxt;
			sel_r    <= sel_nxt;
			found_r  <= found_nxt;
			armed_r  <= armed_nxt;
			abt_r    <= abt_nxt;
			pend_r   <= pend_nxt;
			tx_req_r <= tx_req_nxt;
			tx_idx_r <= tx_idx_nxt;
			irq_r    <= irq_any;
			wb_pend_r <= wb_pend_nxt;
			wb_idx_r  <= wb_idx_nxt;
		end
	end

	assign tx_req           = tx_req_r;
	assign tx_idx           = tx_idx_r;
	assign buffer_done_flag = flags;
	assign irq              = irq_r;
	assign rescan_pending   = pend_r;

	////////////////////////////////////////////////////////////////////////////
	// checks
	a_tx_arms_pend: assert property (@(posedge clk) disable iff (!resetn)
		cs_wr && cs_code == `CTXM_CODE_TX |=> pend_r || state_r == ST_SCAN)
		else $error("transmit code write not latched for rescan");
	a_abort_flags: assert property (@(posedge clk) disable iff (!resetn)
		cs_wr && cs_code == `CTXM_CODE_ABORT && abort_enable && armed_r[cs_idx] && !tx_busy && !tx_done
		|=> flags[$past(cs_idx)])
		else $error("abort did not set completion flag");
	a_irq_mask: assert property (@(posedge clk) disable iff (!resetn)
		irq |-> $past(|(flags & buffer_int_mask)))
		else $error("interrupt without masked flag");
	a_inact_silent: assert property (@(posedge clk) disable iff (!resetn)
		cs_wr && cs_code == `CTXM_CODE_INACT && !tx_done |=> !armed_r[$past(cs_idx)])
		else $error("inactive code left mailbox armed");
	a_deact_zero: assert property (@(posedge clk) disable iff (!resetn)
		cs_wr && cs_code == `CTXM_CODE_INACT0 |=> !armed_r[$past(cs_idx)])
		else $error("code zero did not deactivate");
	a_arm_tx: assert property (@(posedge clk) disable iff (!resetn)
		cs_wr && cs_code == `CTXM_CODE_TX |=> armed_r[$past(cs_idx)])
		else $error("transmit code did not arm mailbox");
	a_rx_rescan: assert property (@(posedge clk) disable iff (!resetn)
		rx_frame_start && state_r != ST_IDLE |=> pend_r)
		else $error("frame start did not schedule rescan");
	a_scan_bound: assert property (@(posedge clk) disable iff (!resetn)
		state_r == ST_IDLE && pend_r && !tx_busy |=> state_r == ST_SCAN ##16 state_r != ST_SCAN)
		else $error("scan length wrong");
	a_req_armed: assert property (@(posedge clk) disable iff (!resetn)
		tx_req |-> armed_r[tx_idx])
		else $error("request for unarmed mailbox");
	// completion, abort, write-back and interrupt bookkeeping
	a_abort_held: assert property (@(posedge clk) disable iff (!resetn)
		(abt_r & ~armed_r) == '0)
		else $error("abort remembered for an idle mailbox");
	a_done_flag: assert property (@(posedge clk) disable iff (!resetn)
		tx_done && armed_r[tx_idx] |=> flags[$past(tx_idx)])
		else $error("completion did not set flag");
	a_done_silent: assert property (@(posedge clk) disable iff (!resetn)
		tx_done && !armed_r[tx_idx] && !flags[tx_idx] && !(cs_wr && cs_idx == tx_idx) |=> !flags[$past(tx_idx)])
		else $error("inactivated mailbox flagged on completion");
	a_wb_drains: assert property (@(posedge clk) disable iff (!resetn)
		wb_pend_r && !cs_wr && !tx_done |=> !wb_pend_r)
		else $error("waiting sent code not written");
	a_irq_follow: assert property (@(posedge clk) disable iff (!resetn)
		(|(flags & buffer_int_mask)) |=> irq)
		else $error("masked flag raised no interrupt");
endmodule : ctxm_tx_mailbox_ctrl
`default_nettype wire

// *** test/ctxm_bus_model.sv ***
// bus engine model: answers a transmit request with a busy frame and a done pulse
`timescale 1ns/1ps
`default_nettype none
module ctxm_bus_model (
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// engine handshake
	input  wire logic slow,
	input  wire logic tx_req,
	output logic      tx_busy,
	output logic      tx_done
);
	logic [4:0] cnt_r;
	// frame length counter; slow frames leave room for host writes while on the wire
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= 5'h00;
			tx_done <= 1'b0;
		end else begin
			tx_done <= (cnt_r == 5'h01); // bus idles after the frame, nothing received
			if (tx_req)
				cnt_r <= slow ? 5'h14 : 5'h03;
			else if (cnt_r != 5'h00)
				cnt_r <= cnt_r - 5'h01;
		end
	end
	assign tx_busy = (cnt_r != 5'h00);
endmodule : ctxm_bus_model
`default_nettype wire

// *** test/ctxm_tx_mailbox_ctrl_tb_top.sv ***
// self-checking bench for the transmit mailbox control block
`timescale 1ns/1ps
`default_nettype none
module ctxm_tx_mailbox_ctrl_tb_top;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        cs_wr = 1'b0;
	logic [3:0]  cs_idx = 4'h0;
	logic [3:0]  cs_code = 4'h0;
	logic [15:0] flag_clr = 16'h0000;
	logic [15:0] buffer_int_mask = 16'h0000;
	logic        abort_enable = 1'b0;
	logic [3:0]  rd_idx = 4'h0;
	logic        intermission_end = 1'b0;
	logic        rx_frame_start = 1'b0;
	logic        slow = 1'b0;
	logic [3:0]  rd_code, tx_idx, k, k2;
	logic [15:0] buffer_done_flag;
	logic        tx_done, tx_busy, tx_req, irq, rescan_pending;
	int          fail_count = 0;
	int          n_checks = 0;
	always #5 clk = ~clk;
	ctxm_tx_mailbox_ctrl ctxm_tx_mailbox_ctrl_i (.clk, .resetn, .cs_wr, .cs_idx, .cs_code, .flag_clr,
		.buffer_int_mask, .abort_enable, .rd_idx, .rd_code, .intermission_end, .rx_frame_start,
		.tx_done, .tx_busy, .tx_req, .tx_idx, .buffer_done_flag, .irq, .rescan_pending);
	ctxm_bus_model ctxm_bus_model_i (.clk, .resetn, .slow, .tx_req, .tx_busy, .tx_done);
	////////////////////////////////////////////////////////////////////////////////
	// reporting and expectations
	task automatic bad(input string msg);
		fail_count++;
		$display("BAD %0t %s", $time, msg);
	endtask : bad
	task automatic chk_bit(input logic got, input logic exp, input string msg);
		n_checks++;
		if (got !== exp) bad(msg);
	endtask : chk_bit
	task automatic chk_code(input logic [3:0] got, input logic [3:0] exp, input string msg);
		n_checks++;
		if (got !== exp) bad(msg);
	endtask : chk_code
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	function automatic logic exp_irq(input logic [15:0] m, input logic [3:0] i);
		return m[i];
	endfunction : exp_irq
	// mailbox zero is reserved, so traffic uses 1 to 15 only
	function automatic logic [3:0] pick;
		return 4'($urandom % 15 + 1);
	endfunction : pick
	////////////////////////////////////////////////////////////////////////////////
	// host side actions
	task automatic wr(input logic [3:0] i, input logic [3:0] c);
		@(posedge clk);
		cs_wr <= 1'b1;
		cs_idx <= i;
		cs_code <= c;
		@(posedge clk);
		cs_wr <= 1'b0;
	endtask : wr
	task automatic rd_chk(input logic [3:0] i, input logic [3:0] exp, input string msg);
		@(posedge clk);
		rd_idx <= i;
		repeat (2) @(posedge clk);
		#1;
		chk_code(rd_code, exp, msg);
	endtask : rd_chk
	task automatic clr(input logic [3:0] i);
		@(posedge clk);
		flag_clr <= 16'h0001 << i;
		@(posedge clk);
		flag_clr <= 16'h0000;
		#1;
		chk_bit(buffer_done_flag[i], 1'b0, "flag clear");
	endtask : clr
	task automatic prep(input logic [3:0] i, input logic [3:0] c);
		wr(4'h0, 4'h8);
		wr(4'h0, 4'h8);
		clr(i);
		wr(i, c); // id and data have no port here, the code goes last
	endtask : prep
	// bounded wait: 0 request, 1 flag of i, 2 no rescan pending and bus idle
	task automatic wait_on(input int w, input logic [3:0] i);
		int n;
		for (n = 0; n < 200; n++) begin
			// look at the current cycle first: a one-cycle request may already stand
			#1;
			if (w == 0 && tx_req === 1'b1) return;
			if (w == 1 && buffer_done_flag[i] === 1'b1) return;
			if (w == 2 && rescan_pending === 1'b0 && tx_busy === 1'b0) return;
			@(posedge clk);
		end
		bad("wait ran out");
		tally_and_finish();
	endtask : wait_on
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(21266));
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1;
		chk_bit(|{buffer_done_flag, irq, tx_req, rescan_pending}, 1'b0, "reset outputs");
		rd_chk(pick(), 4'h0, "reset code");
		// armed mailboxes with prompt and slow frames under random masks
		for (int j = 0; j < 4; j++) begin
			k = pick();
			buffer_int_mask <= 16'($urandom);
			slow <= j[0];
			prep(k, 4'hC);
			wait_on(0, k);
			chk_code(tx_idx, k, "tx index");
			wait_on(1, k);
			@(posedge clk);
			#1;
			chk_bit(irq, exp_irq(buffer_int_mask, k), "irq gating");
			rd_chk(k, 4'h8, "sent code");
			clr(k);
		end
		// arm a second mailbox while the first frame is on the wire
		slow <= 1'b1;
		k = pick();
		k2 = 4'(k % 15 + 1);
		prep(k, 4'hC);
		wait_on(0, k);
		wr(k2, 4'hC);
		#1;
		chk_bit(rescan_pending, 1'b1, "rescan latched");
		wait_on(0, k2);
		chk_code(tx_idx, k2, "second index");
		wait_on(1, k2);
		clr(k);
		clr(k2);
		// abort before the scan reaches the mailbox
		abort_enable <= 1'b1;
		k = pick();
		wait_on(2, k);
		prep(k, 4'hC);
		wr(k, 4'h9);
		wait_on(1, k);
		rd_chk(k, 4'h9, "aborted code");
		clr(k);
		// abort while the frame is on the wire: it completes and reads back as sent
		prep(k, 4'hC);
		wait_on(0, k);
		wr(k, 4'h9);
		wait_on(1, k);
		rd_chk(k, 4'h8, "abort on wire");
		clr(k);
		// compatible inactivate gives no flag, then code zero deactivates
		abort_enable <= 1'b0;
		k = pick();
		prep(k, 4'hC);
		wr(k, 4'h8);
		repeat (3) @(posedge clk);
		#1;
		chk_bit(buffer_done_flag[k], 1'b0, "silent inactivate");
		wr(k, 4'h0);
		rd_chk(k, 4'h0, "code zero");
		// bus events after intermission each owe a rescan
		for (int j = 0; j < 2; j++) begin
			wait_on(2, k);
			@(posedge clk);
			intermission_end <= (j == 0);
			rx_frame_start <= (j == 1);
			@(posedge clk);
			intermission_end <= 1'b0;
			rx_frame_start <= 1'b0;
			#1;
			chk_bit(rescan_pending, 1'b1, "event rescan");
		end
		tally_and_finish();
	end
endmodule : ctxm_tx_mailbox_ctrl_tb_top
`default_nettype wire
